// *** hw/sadc_pkg.sv ***
package sadc_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] CTRL0_OFS = 12'h000;
   localparam logic [11:0] CTRL1_OFS = 12'h004;
   localparam logic [11:0] RESH_OFS = 12'h008;
   localparam logic [11:0] RESL_OFS = 12'h00c;
   localparam logic [11:0] FLAG_OFS = 12'h010;
   localparam logic [11:0] IEN_OFS = 12'h014;
   localparam logic [11:0] SYS_OFS = 12'h018;
   // Control 0 fields
   localparam int CHS_LSB = 2;
   localparam int CHS_W = 5;
   localparam int GO_BIT = 1;
   localparam int ON_BIT = 0;
   // Control 1 fields, then flag, interrupt enable and sleep bits and result width
   localparam int ALIGN_BIT = 7;
   localparam int CKS_LSB = 4;
   localparam int NREF_BIT = 2;
   localparam int PREF_LSB = 0;
   localparam int FLAG_BIT = 0;
   localparam int IEN_BIT = 0;
   localparam int SLEEP_BIT = 0;
   localparam int RES_BITS = 10;
   // Conversion: one setup bit period plus ten bit periods (11 in total)
   localparam int SETUP_TAD = 1;
   // Bit-period clock choices
   localparam logic [2:0] CKS_DIV2 = 3'h0;
   localparam logic [2:0] CKS_DIV4 = 3'h4;
   localparam logic [2:0] CKS_DIV8 = 3'h1;
   localparam logic [2:0] CKS_DIV16 = 3'h5;
   localparam logic [2:0] CKS_DIV32 = 3'h2;
   localparam logic [2:0] CKS_DIV64 = 3'h6;
   localparam logic [1:0] CKS_RC_LOW = 2'h3;
   // Positive reference choices
   localparam logic [1:0] PREF_VDD = 2'h0;
   localparam logic [1:0] PREF_PIN = 2'h2;
   localparam logic [1:0] PREF_FVR = 2'h3;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_CONV = 2'b10
   } sadc_state_t;
endpackage : sadc_pkg

// *** hw/sadc_seq.sv ***
// Operation
// - Ten-bit result by successive approximation, stored in the result pair.
// - Channel select routes one analog source to the sample-and-hold input.
// - Positive reference: external pin, supply, or fixed 2.048V/4.096V.
// - Negative reference bit picks external pin or ground.
// - Clock select: divide by 2..64 codes, or x11 for the RC clock.
// - One bit period per result bit; whole conversion lasts 11.5 periods (the code takes 11: one setup plus ten).
// - Divided clock tracks system clock; RC clock does not.
// - Done flag sets at every conversion end regardless of enable.
// - Interrupt request raised only when the done interrupt is enabled.
// - Converter works in Sleep only with the RC clock selected.
// - Enabled done interrupt wakes the device from Sleep.
// - Align bit places result left or right justified.
// - Converter active only while enabled; off draws no current.
// - Writing one to go starts a conversion; not with the enable write.
// - On completion clear go, set flag, load result.
// - Clearing go mid-conversion stores partial result, filling with last bit.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module sadc_seq (
   input wire logic CORE_CLK, // System clock
   input wire logic ARST_N, // Asynchronous reset, active low
   input wire logic RC_TICK, // One-cycle tick per RC clock bit period
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic PWRITE, // APB direction
   input wire logic [11:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   input wire logic CMP_IN, // Comparator: sample above DAC level
   output logic [4:0] CHANNEL_SEL, // Analog mux select
   output logic [1:0] POS_REF_SEL, // Positive reference select
   output logic NEG_REF_SEL, // Negative reference select
   output logic [9:0] DAC_CODE, // Trial code to the capacitor DAC
   output logic SAMPLE_HOLD, // High while the input is held
   output logic ANALOG_EN, // Analog bias enable
   output logic CONV_DONE_IRQ, // Interrupt request level
   output logic WAKE_REQ // Wake request while sleeping
);
   typedef struct packed {
      logic [4:0] channel_sel;
      logic go;
      logic on;
      logic align;
      logic [2:0] cks;
      logic nref;
      logic [1:0] pref;
      logic flag;
      logic ien;
      logic sleep;
      logic [9:0] result;
      logic [9:0] trial;
      logic [3:0] bit_idx;
      logic last_bit;
      logic [5:0] div_cnt;
      sadc_pkg::sadc_state_t st;
      logic [31:0] rdata;
   } sadc_regs_t;

   sadc_regs_t s_q;
   sadc_regs_t s_d;
   logic wr;
   logic rd;
   logic mapped;
   logic tad_tick;
   logic use_rc;
   logic run_ok;
   logic [5:0] div_last;
   logic [15:0] res_pair;

   assign wr = PSEL && PENABLE && PWRITE;
   // Read data is captured in the setup phase so it stands in the access phase
   assign rd = PSEL && !PENABLE && !PWRITE;
   assign mapped = PADDR inside {sadc_pkg::CTRL0_OFS, sadc_pkg::CTRL1_OFS,
      sadc_pkg::RESH_OFS, sadc_pkg::RESL_OFS, sadc_pkg::FLAG_OFS,
      sadc_pkg::IEN_OFS, sadc_pkg::SYS_OFS};
   assign use_rc = s_q.cks[1:0] == sadc_pkg::CKS_RC_LOW;
   // Outside Sleep any clock may run; in Sleep only the RC clock keeps going
   assign run_ok = s_q.on && (!s_q.sleep || use_rc);

   always_comb begin
      case (s_q.cks)
         sadc_pkg::CKS_DIV2: div_last = 6'd1;
         sadc_pkg::CKS_DIV4: div_last = 6'd3;
         sadc_pkg::CKS_DIV8: div_last = 6'd7;
         sadc_pkg::CKS_DIV16: div_last = 6'd15;
         sadc_pkg::CKS_DIV32: div_last = 6'd31;
         sadc_pkg::CKS_DIV64: div_last = 6'd63;
         default: div_last = 6'd0;
      endcase
   end
   // Divided periods scale with CORE_CLK, RC periods follow RC_TICK only
   assign tad_tick = use_rc ? RC_TICK : (s_q.div_cnt == div_last);

   always_comb begin
      // Justification is applied on read so a later flip reformats the result
      if (s_q.align) begin
         res_pair = {6'h00, s_q.result};
      end else begin
         res_pair = {s_q.result, 6'h00};
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.rdata = sadc_pkg::RD_ZERO;
      if (s_q.st == sadc_pkg::ST_IDLE || use_rc || s_q.div_cnt == div_last) begin
         s_d.div_cnt = 6'd0;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 6'd1;
      end
      if (rd) begin
         case (PADDR)
            sadc_pkg::CTRL0_OFS: s_d.rdata = {24'h0, 1'b0, s_q.channel_sel,
               s_q.go, s_q.on};
            sadc_pkg::CTRL1_OFS: s_d.rdata = {24'h0, s_q.align, s_q.cks,
               1'b0, s_q.nref, s_q.pref};
            sadc_pkg::RESH_OFS: s_d.rdata = {24'h0, res_pair[15:8]};
            sadc_pkg::RESL_OFS: s_d.rdata = {24'h0, res_pair[7:0]};
            sadc_pkg::FLAG_OFS: s_d.rdata = {31'h0, s_q.flag};
            sadc_pkg::IEN_OFS: s_d.rdata = {31'h0, s_q.ien};
            sadc_pkg::SYS_OFS: s_d.rdata = {31'h0, s_q.sleep};
            default: s_d.rdata = sadc_pkg::RD_ZERO;
         endcase
      end
      if (wr) begin
         case (PADDR)
            sadc_pkg::CTRL0_OFS: begin
               s_d.channel_sel = PWDATA[sadc_pkg::CHS_LSB +: sadc_pkg::CHS_W];
               s_d.on = PWDATA[sadc_pkg::ON_BIT];
               // Go is only honoured if the converter was already on
               s_d.go = PWDATA[sadc_pkg::GO_BIT] && s_q.on;
            end
            sadc_pkg::CTRL1_OFS: begin
               s_d.align = PWDATA[sadc_pkg::ALIGN_BIT];
               s_d.cks = PWDATA[sadc_pkg::CKS_LSB +: 3];
               s_d.nref = PWDATA[sadc_pkg::NREF_BIT];
               s_d.pref = PWDATA[sadc_pkg::PREF_LSB +: 2];
            end
            sadc_pkg::FLAG_OFS: begin
               s_d.flag = PWDATA[sadc_pkg::FLAG_BIT];
            end
            sadc_pkg::IEN_OFS: s_d.ien = PWDATA[sadc_pkg::IEN_BIT];
            sadc_pkg::SYS_OFS: s_d.sleep = PWDATA[sadc_pkg::SLEEP_BIT];
            default: s_d.channel_sel = s_q.channel_sel;
         endcase
      end
      case (s_q.st)
         sadc_pkg::ST_IDLE: begin
            if (s_q.go && run_ok) begin
               s_d.st = sadc_pkg::ST_SETUP;
               s_d.trial = 10'h200;
               s_d.bit_idx = 4'd9;
            end
         end
         sadc_pkg::ST_SETUP: begin
            if (tad_tick) begin
               s_d.st = sadc_pkg::ST_CONV;
            end
         end
         sadc_pkg::ST_CONV: begin
            if (tad_tick) begin
               s_d.trial[s_q.bit_idx] = CMP_IN;
               s_d.last_bit = CMP_IN;
               if (s_q.bit_idx == 4'd0) begin
                  s_d.st = sadc_pkg::ST_IDLE;
                  s_d.go = 1'b0;
                  s_d.flag = 1'b1;
                  s_d.result = {s_q.trial[9:1], CMP_IN};
               end else begin
                  s_d.bit_idx = s_q.bit_idx - 4'd1;
                  s_d.trial[s_q.bit_idx - 4'd1] = 1'b1;
               end
            end
         end
         default: s_d.st = sadc_pkg::ST_IDLE;
      endcase
      // Abort paths: software clearing go, or losing enable/clock in Sleep
      if (s_q.st != sadc_pkg::ST_IDLE && s_d.st != sadc_pkg::ST_IDLE &&
            (!s_d.go || !run_ok)) begin
         s_d.st = sadc_pkg::ST_IDLE;
         s_d.go = 1'b0;
         if (s_q.st == sadc_pkg::ST_CONV && s_q.bit_idx != 4'd9) begin
            for (int i = 0; i < sadc_pkg::RES_BITS; i++) begin
               if (i <= int'(s_q.bit_idx)) begin
                  s_d.result[i] = s_q.last_bit;
               end else begin
                  s_d.result[i] = s_q.trial[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.rdata;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign CHANNEL_SEL = s_q.channel_sel;
   assign POS_REF_SEL = s_q.pref;
   assign NEG_REF_SEL = s_q.nref;
   assign DAC_CODE = s_q.trial;
   assign SAMPLE_HOLD = s_q.st != sadc_pkg::ST_IDLE;
   assign ANALOG_EN = run_ok;
   assign CONV_DONE_IRQ = s_q.flag && s_q.ien;
   assign WAKE_REQ = s_q.sleep && s_q.flag && s_q.ien;
endmodule : sadc_seq

// *** verification/sadc_fe_model.sv ***
`timescale 1ns/10ps
module sadc_fe_model (
   input wire logic clk, // System clock
   input wire logic [9:0] vin, // Held input level as a code
   input wire logic [9:0] dac_code, // Trial code
   input wire logic hold, // Input held
   output logic cmp // Comparator result
);
   logic last_q = 1'b0;
   always @(posedge clk) last_q <= cmp;
   // Toggles outside a conversion so a stale bit never looks valid
   assign cmp = hold ? (vin >= dac_code) : !last_q;
endmodule : sadc_fe_model

// *** verification/sadc_props.sv ***
`timescale 1ns/10ps
module sadc_props (
   input wire logic CORE_CLK, // Clock
   input wire logic ARST_N, // Reset
   input wire logic PSEL, // Select
   input wire logic PENABLE, // Access
   input wire logic PWRITE, // Write
   input wire logic [11:0] PADDR, // Address
   input wire logic [31:0] PWDATA, // Write data
   input wire logic [4:0] CHANNEL_SEL, // Mux
   input wire logic [1:0] POS_REF_SEL, // Pos ref
   input wire logic NEG_REF_SEL, // Neg ref
   input wire logic [9:0] DAC_CODE, // Trial code
   input wire logic SAMPLE_HOLD, // Hold
   input wire logic ANALOG_EN, // Bias
   input wire logic CONV_DONE_IRQ, // Irq
   input wire logic WAKE_REQ // Wake
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   logic [31:0] wd_q;
   logic wr;
   always_ff @(posedge CORE_CLK) wd_q <= PWDATA;
   assign wr = PSEL && PENABLE && PWRITE;
   AST_CHS: assert property (wr && PADDR == sadc_pkg::CTRL0_OFS
      |=> CHANNEL_SEL == wd_q[6:2]) else $error("channel select wrong");
   AST_REF: assert property (wr && PADDR == sadc_pkg::CTRL1_OFS
      |=> POS_REF_SEL == wd_q[1:0] && NEG_REF_SEL == wd_q[2])
      else $error("reference select wrong");
   AST_START: assert property ($rose(SAMPLE_HOLD) |->
      DAC_CODE == 10'h200) else $error("search not at midscale");
   AST_ON: assert property ($rose(SAMPLE_HOLD) |-> ANALOG_EN)
      else $error("conversion while off");
   AST_OFF: assert property ($fell(ANALOG_EN) |-> ##[0:2]
      !SAMPLE_HOLD) else $error("hold kept while off");
   AST_HOLD: assert property ($rose(SAMPLE_HOLD) |=>
      SAMPLE_HOLD [*8]) else $error("conversion too short");
   AST_WAKE: assert property (WAKE_REQ |-> CONV_DONE_IRQ)
      else $error("wake without irq");
   AST_IEN: assert property (wr && PADDR == sadc_pkg::IEN_OFS &&
      !PWDATA[0] |=> !CONV_DONE_IRQ) else $error("irq while masked");
   C_CONV: cover property ($rose(SAMPLE_HOLD));
   C_IRQ: cover property ($rose(CONV_DONE_IRQ));
   C_WAKE: cover property ($rose(WAKE_REQ));
endmodule : sadc_props
bind sadc_seq sadc_props u_props (.*);

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module tb_top;
   logic clk = 0, rst_n = 0, rc = 0, psel = 0, pen = 0, pwr = 0, cmp, err, ok;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, r;
   logic [9:0] vin = 0, dac, e, res;
   logic [4:0] channel_sel;
   logic [1:0] pref;
   logic nref, sh, aen, irq, wake, rdy, slv;
   logic [2:0] ck[7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
   int dv[7] = '{2, 4, 8, 16, 32, 64, 7};
   int n_errors = 0, total_checks = 0, cyc = 0, n;
   sadc_seq uut (.CORE_CLK(clk), .ARST_N(rst_n), .RC_TICK(rc), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(rdy), .PSLVERR(slv), .CMP_IN(cmp), .CHANNEL_SEL(channel_sel),
      .POS_REF_SEL(pref), .NEG_REF_SEL(nref), .DAC_CODE(dac),
      .SAMPLE_HOLD(sh), .ANALOG_EN(aen), .CONV_DONE_IRQ(irq), .WAKE_REQ(wake));
   sadc_fe_model u_fe (.clk(clk), .vin(vin), .dac_code(dac), .hold(sh),
      .cmp(cmp));
   initial begin
      forever #5 clk = ~clk;
   end
   // RC bit clock ticks every seventh cycle
   always @(posedge clk) begin
      cyc++;
      rc <= (cyc % 7 == 0);
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   // Response and read data are taken at the edge where ready is high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1; pen <= 0; pa <= a; pwr <= w; pwd <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      err = slv;
      r = prd;
      psel <= 0; pen <= 0;
      @(posedge clk);
   endtask : apb
   task automatic conv(input logic [31:0] c0);
      n = 0;
      repeat (4) @(posedge clk);
      apb(sadc_pkg::CTRL0_OFS, 1, c0);
      @(negedge clk);
      while (sh === 1'b1 && n < 2000) begin
         n++;
         @(negedge clk);
      end
      @(posedge clk);
   endtask : conv
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      apb(sadc_pkg::CTRL1_OFS, 1, 32'h86);
      `CHK({pref, nref}, 3'h5)
      apb(sadc_pkg::CTRL0_OFS, 1, 32'h57);
      `CHK({channel_sel, sh}, 6'h2a)
      apb(sadc_pkg::CTRL0_OFS, 0, 0);
      `CHK(r, 32'h55)
      for (int i = 0; i < 7; i++) begin
         vin <= 10'h155 + 10'(i * 73);
         if (i == 6) begin
            apb(sadc_pkg::IEN_OFS, 1, 1);
            apb(sadc_pkg::SYS_OFS, 1, 1);
         end
         apb(sadc_pkg::CTRL1_OFS, 1, {24'h0, i[0], ck[i], 4'h7});
         apb(sadc_pkg::FLAG_OFS, 1, 0);
         conv(32'h57);
         `CHK(n >= 11 * dv[i] - 1 - (i / 6) * 7 && n <= 11 * dv[i] + 1, 1'b1)
         apb(sadc_pkg::RESH_OFS, 0, 0);
         `CHK(r, i[0] ? {30'h0, vin[9:8]} : {24'h0, vin[9:2]})
         apb(sadc_pkg::RESL_OFS, 0, 0);
         `CHK(r, i[0] ? {24'h0, vin[7:0]} : {24'h0, vin[1:0], 6'h0})
         apb(sadc_pkg::CTRL0_OFS, 0, 0);
         `CHK(r, 32'h55)
         apb(sadc_pkg::FLAG_OFS, 0, 0);
         `CHK(r, 32'h1)
         `CHK({irq, wake}, {2{i == 6}})
      end
      apb(sadc_pkg::CTRL1_OFS, 1, 32'he7);
      `CHK(aen, 1'b0)
      apb(sadc_pkg::SYS_OFS, 1, 0);
      apb(sadc_pkg::FLAG_OFS, 1, 0);
      `CHK({aen, irq}, 2'h2)
      vin <= 10'h2a5;
      apb(sadc_pkg::CTRL0_OFS, 1, 32'h57);
      repeat (300) @(posedge clk);
      apb(sadc_pkg::CTRL0_OFS, 1, 32'h55);
      apb(sadc_pkg::RESH_OFS, 0, 0);
      res[9:8] = r[1:0];
      apb(sadc_pkg::RESL_OFS, 0, 0);
      res[7:0] = r[7:0];
      ok = 0;
      for (int k = 1; k < 10; k++) begin
         e = (10'h1 << (10 - k)) - 10'h1;
         e = vin[10 - k] ? (vin | e) : (vin & ~e);
         ok = ok | (res === e);
      end
      `CHK(ok, 1'b1)
      apb(sadc_pkg::CTRL0_OFS, 1, 0);
      `CHK(aen, 1'b0)
      apb(12'h01c, 0, 0);
      `CHK({err, r}, 33'h1_0000_0000)
      end_of_test();
   end
endmodule : tb_top
